// [src/pfs_pkg.sv]
// Purpose: Shared constants and types for the current-loop frame and slot timer.
// Assumes: 100 MHz system clock; 16 MHz main rate derived from it by accumulation.
// Notes:   Cycle, slot, bit and frame durations are counted in ticks of the 2 MHz or 2.67 MHz bit clock.
package pfs_pkg;

   // Transmission modes
   typedef enum logic [2:0] {
      PFS_A10_250 = 3'h0,   // Asynchronous 10-bit, 250 us cycle
      PFS_A10_500 = 3'h1,   // Asynchronous 10-bit, 500 us cycle
      PFS_P20_1L  = 3'h2,   // Synchronous 20-bit, one slot, low rate
      PFS_P20_2L  = 3'h3,   // Synchronous 20-bit, two slots, low rate
      PFS_P20_2H  = 3'h4,   // Synchronous 20-bit, two slots, high rate
      PFS_P20_3H  = 3'h5,   // Synchronous 20-bit, three slots, high rate
      PFS_P16_3H  = 3'h6,   // Synchronous 16-bit CRC, three slots
      PFS_P16_4H  = 3'h7    // Synchronous 16-bit CRC, four slots, 1000 us
   } pfs_mode_t;

   // Controller states, one-hot
   typedef enum logic [2:0] {
      PFS_ST_IDLE  = 3'b001,
      PFS_ST_WAIT  = 3'b010,
      PFS_ST_FRAME = 3'b100
   } pfs_state_t;

   // Clock derivation
   localparam int SYS_MHZ  = 100;
   localparam int MAIN_MHZ = 16;
   localparam int DIV_LO   = 8;    // 16 MHz / 8 = 2 MHz
   localparam int DIV_HI   = 6;    // 16 MHz / 6 = 2.67 MHz

   // Counter width, large enough for the 1000 us cycle at 2.67 MHz
   localparam int CNT_W = 12;
   localparam int BIT_W = 5;

   // Trigger detection bound
   localparam int TRIG_MAX_US  = 10;
   localparam int TRIG_MAX_CYC = TRIG_MAX_US * SYS_MHZ;

   // Asynchronous cycle lengths, 2 MHz ticks
   localparam logic [CNT_W-1:0] CYC_250L = 12'h1F4;   // 500
   localparam logic [CNT_W-1:0] CYC_500L = 12'h3E8;   // 1000

   // Bit durations
   localparam logic [CNT_W-1:0] BIT_L = 12'h010;      // 16 ticks of 2 MHz
   localparam logic [CNT_W-1:0] BIT_H = 12'h00E;      // 14 ticks of 2.67 MHz

   // Frame durations
   localparam logic [CNT_W-1:0] FRM_10L = 12'h0D0;    // 208
   localparam logic [CNT_W-1:0] FRM_20L = 12'h190;    // 400
   localparam logic [CNT_W-1:0] FRM_20H = 12'h15E;    // 350
   localparam logic [CNT_W-1:0] FRM_16H = 12'h126;    // 294

   // Slot start counts after the trigger
   localparam logic [CNT_W-1:0] S1_20L    = 12'h058;  // 88
   localparam logic [CNT_W-1:0] S2_20L    = 12'h21C;  // 540
   localparam logic [CNT_W-1:0] S1_2H     = 12'h077;  // 119
   localparam logic [CNT_W-1:0] S2_2H     = 12'h23A;  // 570
   localparam logic [CNT_W-1:0] S1_3H     = 12'h070;  // 112
   localparam logic [CNT_W-1:0] S2_3H     = 12'h1EA;  // 490
   localparam logic [CNT_W-1:0] S2_3H_V12 = 12'h1E2;  // 482
   localparam logic [CNT_W-1:0] S2_3H_V23 = 12'h20C;  // 524
   localparam logic [CNT_W-1:0] S3_3H     = 12'h389;  // 905

   // Fourth slot, nominal time converted to 2.67 MHz ticks
   localparam int SLOT4_NS = 493500;
   localparam int HI_KHZ   = MAIN_MHZ * 1000 / DIV_HI;
   localparam logic [CNT_W-1:0] S4_4H = CNT_W'(SLOT4_NS * MAIN_MHZ / DIV_HI / 1000);

endpackage

// [src/pfs_clk_div.sv]
// Purpose: Bit clock enables from the 16 MHz main rate.
// Assumes: System clock is a whole number of MHz above 16 MHz.
// Notes:   Tick spacing jitters by one system cycle; average rates are exact.
`timescale 1ns/1ns
module pfs_clk_div
   import pfs_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Enables
   output logic      tick_lo,
   output logic      tick_hi
);

   logic [6:0] acc_reg;
   logic       main_tick;
   logic [2:0] lo_cnt_reg;
   logic [2:0] hi_cnt_reg;

   // Fractional accumulator makes 16 MHz from 100 MHz without a PLL
   always_ff @(posedge clock) begin
      if (rst) begin
         acc_reg <= 7'h00;
      end else if (acc_reg + 7'(MAIN_MHZ) >= 7'(SYS_MHZ)) begin
         acc_reg <= acc_reg + 7'(MAIN_MHZ) - 7'(SYS_MHZ);
      end else begin
         acc_reg <= acc_reg + 7'(MAIN_MHZ);
      end
   end

   assign main_tick = (acc_reg + 7'(MAIN_MHZ) >= 7'(SYS_MHZ));

   // Divide by 8 and by 6 for the two bit clocks
   always_ff @(posedge clock) begin
      if (rst) begin
         lo_cnt_reg <= 3'h0;
         hi_cnt_reg <= 3'h0;
         tick_lo    <= 1'b0;
         tick_hi    <= 1'b0;
      end else begin
         tick_lo <= 1'b0;
         tick_hi <= 1'b0;
         if (main_tick) begin
            lo_cnt_reg <= (lo_cnt_reg == 3'(DIV_LO - 1)) ? 3'h0 : lo_cnt_reg + 3'h1;
            hi_cnt_reg <= (hi_cnt_reg == 3'(DIV_HI - 1)) ? 3'h0 : hi_cnt_reg + 3'h1;
            tick_lo    <= (lo_cnt_reg == 3'(DIV_LO - 1));
            tick_hi    <= (hi_cnt_reg == 3'(DIV_HI - 1));
         end
      end
   end

endmodule // pfs_clk_div

// [src/pfs_sync_edge.sv]
// Purpose: Synchronise the sync pulse pin and mark its leading edge.
// Assumes: Sync pulse is wider than two system cycles.
// Notes:   Latency from pin rise to pulse is two system cycles.
`timescale 1ns/1ns
module pfs_sync_edge
   import pfs_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Pin side
   input  wire logic sync_in,
   // Detection
   output logic      sync_det
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Two-stage synchroniser, then one stage for the edge
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= sync_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Few cycles, far inside the detection bound
   assign sync_det = sync_reg & ~last_reg;

endmodule // pfs_sync_edge

// [src/pfs_frame_slot_timer.sv]
// Purpose: Frame and slot timing for a current-loop sensor transmitter.
// Assumes: Mode and slot inputs are steady while run_en is high.
// Notes:   Outputs mark frame and bit boundaries; frame content lies elsewhere.
`timescale 1ns/1ns
module pfs_frame_slot_timer
   import pfs_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Link pin
   input  wire logic             sync_in,
   // Configuration
   input  wire logic             run_en,
   input  wire pfs_mode_t        mode,
   input  wire logic [1:0]       angle_slot,
   input  wire logic             vel_en,
   // Frame timing outputs
   output logic                  frame_start,
   output logic                  bit_strobe,
   output logic                  frame_active,
   output logic                  frame_is_vel,
   output logic [1:0]            frame_slot,
   output logic [BIT_W-1:0]      bit_index,
   output logic                  tx_abort,
   output logic                  sync_seen
);

   // Enables and detection
   logic tick_lo;
   logic tick_hi;
   logic sync_det;

   // One divider serves both rates, so they never drift apart
   pfs_clk_div u_div (
      .clock   (clock),
      .rst     (rst),
      .tick_lo (tick_lo),
      .tick_hi (tick_hi)
   );

   // Only the edge pulse of the pin reaches the sequencer
   pfs_sync_edge u_sync (
      .clock    (clock),
      .rst      (rst),
      .sync_in  (sync_in),
      .sync_det (sync_det)
   );

   // Mode properties
   // Small functions keep the per-mode tables in one place
   function automatic logic mode_hi(input pfs_mode_t m);
      return (m == PFS_P20_2H) || (m == PFS_P20_3H) ||
             (m == PFS_P16_3H) || (m == PFS_P16_4H);
   endfunction

   // Free-running modes ignore the sync line
   function automatic logic mode_async(input pfs_mode_t m);
      return (m == PFS_A10_250) || (m == PFS_A10_500);
   endfunction

   // Slots per cycle; zero in the free-running modes
   function automatic logic [2:0] slot_count(input pfs_mode_t m);
      unique case (m)
         PFS_P20_1L:             return 3'h1;
         PFS_P20_2L, PFS_P20_2H: return 3'h2;
         PFS_P20_3H, PFS_P16_3H: return 3'h3;
         PFS_P16_4H:             return 3'h4;
         default:                return 3'h0;
      endcase
   endfunction

   // Bit length in ticks of the selected bit clock
   function automatic logic [CNT_W-1:0] bit_len(input pfs_mode_t m);
      return mode_hi(m) ? BIT_H : BIT_L;
   endfunction

   // Frame length in ticks of the selected bit clock
   function automatic logic [CNT_W-1:0] frame_len(input pfs_mode_t m);
      unique case (m)
         PFS_A10_250, PFS_A10_500: return FRM_10L;
         PFS_P20_1L, PFS_P20_2L:   return FRM_20L;
         PFS_P20_2H, PFS_P20_3H:   return FRM_20H;
         default:                  return FRM_16H;
      endcase
   endfunction

   // Slot four exists only in the four-slot mode
   // Start count of a slot; slot two of the three-slot modes depends on pairing
   function automatic logic [CNT_W-1:0] slot_start(input pfs_mode_t m,
                                                   input logic [1:0] s,
                                                   input logic       v,
                                                   input logic [1:0] a);
      logic [CNT_W-1:0] r;
      r = S1_20L;
      unique case (m)
         PFS_P20_1L, PFS_P20_2L:
            r = (s == 2'h0) ? S1_20L : S2_20L;
         PFS_P20_2H:
            r = (s == 2'h0) ? S1_2H : S2_2H;
         PFS_P20_3H, PFS_P16_3H, PFS_P16_4H: begin
            if (s == 2'h0) begin
               r = S1_3H;
            end else if (s == 2'h1) begin
               if (v && a == 2'h0) begin
                  r = S2_3H_V12;
               end else if (v && a == 2'h1) begin
                  r = S2_3H_V23;
               end else begin
                  r = S2_3H;
               end
            end else if (s == 2'h2) begin
               r = S3_3H;
            end else begin
               r = S4_4H;
            end
         end
         default: r = S1_20L;
      endcase
      return r;
   endfunction

   // Selected bit clock and derived settings
   // All follow mode, which must stay put during a run
   logic             tick;
   logic             is_async;
   logic             vel_ok;
   logic             slot_ok;
   logic [CNT_W-1:0] cur_start;
   logic [CNT_W-1:0] cur_frame;
   logic [CNT_W-1:0] cur_bit;
   logic [CNT_W-1:0] cur_cycle;

   // Rate follows the mode so all counters share one time base
   assign tick      = mode_hi(mode) ? tick_hi : tick_lo;
   assign is_async  = mode_async(mode);
   assign slot_ok   = ({1'b0, angle_slot} < slot_count(mode));
   // Velocity needs a following slot, so single-slot mode never pairs
   assign vel_ok    = vel_en && ({1'b0, angle_slot} + 3'h1 < slot_count(mode));
   assign cur_frame = frame_len(mode);
   assign cur_bit   = bit_len(mode);
   // Cycle length matters only in the free-running modes
   assign cur_cycle = (mode == PFS_A10_250) ? CYC_250L : CYC_500L;

   // Control state
   // One sequencer serves free-running and slot modes
   pfs_state_t       state_reg;
   logic [CNT_W-1:0] slot_tmr_reg;
   logic [CNT_W-1:0] cyc_tmr_reg;
   logic [CNT_W-1:0] frm_cnt_reg;
   logic [CNT_W-1:0] bit_cnt_reg;
   logic [1:0]       slot_reg;
   logic             second_reg;
   logic             run_q_reg;

   // Decoded events, all but restart qualified by the selected tick
   logic [CNT_W-1:0] slot_tmr_next;
   logic             async_fire;
   logic             slot_hit;
   logic             frame_end;
   logic             bit_end;
   logic             restart;

   // Start count follows the slot now waited for
   assign cur_start     = slot_start(mode, slot_reg, vel_ok, angle_slot);
   assign slot_tmr_next = slot_tmr_reg + 12'h001;

   // A sync aimed outside the mode's slots starts nothing
   assign restart       = run_en && !is_async && sync_det && slot_ok;

   // Waiting for the arm stage keeps the first tick from
   // being used twice, which would stretch the first period
   assign async_fire    = run_en && run_q_reg && is_async && tick && (cyc_tmr_reg == 12'h000);

   // Timer value after this tick equals the start count
   assign slot_hit      = (state_reg == PFS_ST_WAIT) && tick && (slot_tmr_next == cur_start);

   // Bit and frame ends fall on the last tick of a span
   assign bit_end       = tick && (bit_cnt_reg + 12'h001 == cur_bit);
   assign frame_end     = (state_reg == PFS_ST_FRAME) && tick &&
                          (frm_cnt_reg + 12'h001 == cur_frame);

   // Arm latch: run_en edge releases the async cycle from a clean phase
   always_ff @(posedge clock) begin
      if (rst) begin
         run_q_reg <= 1'b0;
      end else begin
         run_q_reg <= run_en;
      end
   end

   // Asynchronous cycle counter, free of any sync pulse
   // Held at zero while stopped, so each run starts clean
   always_ff @(posedge clock) begin
      if (rst || !run_en || !is_async || !run_q_reg) begin
         cyc_tmr_reg <= 12'h000;
      end else if (tick) begin
         if (cyc_tmr_reg + 12'h001 == cur_cycle) begin
            cyc_tmr_reg <= 12'h000;
         end else begin
            cyc_tmr_reg <= cyc_tmr_reg + 12'h001;
         end
      end
   end

   // Slot timer measures bit-clock ticks since the last sync
   // Saturating keeps a lost sync from faking a slot
   always_ff @(posedge clock) begin
      if (rst) begin
         slot_tmr_reg <= 12'h000;
      end else if (restart) begin
         slot_tmr_reg <= 12'h000;
      end else if (tick && slot_tmr_reg != 12'hFFF) begin
         slot_tmr_reg <= slot_tmr_next;                // Saturates rather than wraps
      end
   end

   // Sequencer: wait for slot, send frame, then optional velocity slot
   always_ff @(posedge clock) begin
      if (rst || !run_en) begin
         state_reg  <= PFS_ST_IDLE;
         slot_reg   <= 2'h0;
         second_reg <= 1'b0;
      end else if (restart) begin
         state_reg  <= PFS_ST_WAIT;
         slot_reg   <= angle_slot;
         second_reg <= vel_ok;
      end else begin
         unique case (state_reg)
            PFS_ST_IDLE: begin
               // Only the free-running cycle leaves idle alone
               if (async_fire) begin
                  state_reg <= PFS_ST_FRAME;
               end
            end
            PFS_ST_WAIT: begin
               // A free-running mode drops the pending slot
               if (is_async) begin
                  state_reg <= PFS_ST_IDLE;
               end else if (slot_hit) begin
                  state_reg <= PFS_ST_FRAME;
               end
            end
            PFS_ST_FRAME: begin
               if (frame_end) begin
                  if (second_reg) begin
                     // Velocity frame waits for the next slot
                     state_reg  <= PFS_ST_WAIT;
                     slot_reg   <= slot_reg + 2'h1;
                     second_reg <= 1'b0;
                  end else begin
                     state_reg <= PFS_ST_IDLE;
                  end
               end
            end
            // Codes that are not one-hot fall back to idle
            default: state_reg <= PFS_ST_IDLE;
         endcase
      end
   end

   // Frame and bit counters
   // Both restart at each frame start and accepted sync
   logic start_now;
   assign start_now = !restart && (async_fire && state_reg == PFS_ST_IDLE || slot_hit);

   always_ff @(posedge clock) begin
      if (rst || !run_en || restart || start_now) begin
         frm_cnt_reg <= 12'h000;
         bit_cnt_reg <= 12'h000;
      end else if (state_reg == PFS_ST_FRAME && tick) begin
         frm_cnt_reg <= frm_cnt_reg + 12'h001;
         bit_cnt_reg <= bit_end ? 12'h000 : bit_cnt_reg + 12'h001;
      end
   end

   // Output pulses and frame markers, all registered
   // The first bit starts together with the frame
   always_ff @(posedge clock) begin
      if (rst) begin
         frame_start  <= 1'b0;
         bit_strobe   <= 1'b0;
         tx_abort     <= 1'b0;
         sync_seen    <= 1'b0;
      end else begin
         frame_start  <= start_now;
         bit_strobe   <= start_now ||
                         (state_reg == PFS_ST_FRAME && bit_end && !frame_end && !restart);
         // Abort only when something was scheduled or on the wire
         tx_abort     <= restart && (state_reg != PFS_ST_IDLE);
         // Reported even for a slot the mode lacks
         sync_seen    <= run_en && !is_async && sync_det;
      end
   end

   // Frame identity and bit position
   // Abort and frame end win over a start in one cycle
   always_ff @(posedge clock) begin
      if (rst || !run_en) begin
         frame_active <= 1'b0;
         frame_is_vel <= 1'b0;
         frame_slot   <= 2'h0;
         bit_index    <= '0;
      end else if (restart || frame_end) begin
         frame_active <= 1'b0;
         bit_index    <= '0;
      end else if (start_now) begin
         frame_active <= 1'b1;
         // A frame outside the angle slot is the velocity one
         frame_is_vel <= !is_async && (slot_reg != angle_slot);
         frame_slot   <= is_async ? 2'h0 : slot_reg;
         bit_index    <= '0;
      end else if (state_reg == PFS_ST_FRAME && bit_end) begin
         bit_index    <= bit_index + 5'h01;
      end
   end

endmodule // pfs_frame_slot_timer

// [sim/pfs_frame_slot_timer_props.sv]
// Purpose: Port-level timing checks for the frame and slot timer.
// Assumes: Bit ticks of 50 and 37.5 system cycles; small jitter allowed.
// Notes:   Frame length is not checked when a sync or run_en cut it short.
`timescale 1ns/1ns
module pfs_fst_props
   import pfs_pkg::*;
(
   // Clock and reset
   input wire logic             clock,
   input wire logic             rst,
   // Timer inputs
   input wire logic             sync_in,
   input wire logic             run_en,
   input wire pfs_mode_t        mode,
   input wire logic [1:0]       angle_slot,
   input wire logic             vel_en,
   // Timer outputs
   input wire logic             frame_start,
   input wire logic             bit_strobe,
   input wire logic             frame_active,
   input wire logic             frame_is_vel,
   input wire logic [1:0]       frame_slot,
   input wire logic [BIT_W-1:0] bit_index,
   input wire logic             tx_abort,
   input wire logic             sync_seen
);
   localparam int TRIG_CYC = 1000;
   logic [15:0] act_cnt_reg;
   logic [15:0] gap_cnt_reg;
   int          len_exp;
   int          gap_exp;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Expected frame and bit lengths in system cycles
   always_comb begin
      case (mode)
         PFS_A10_250, PFS_A10_500: len_exp = 10400;
         PFS_P20_1L, PFS_P20_2L:   len_exp = 20000;
         PFS_P20_2H, PFS_P20_3H:   len_exp = 13125;
         default:                  len_exp = 11025;
      endcase
      gap_exp = (mode >= PFS_P20_2H) ? 525 : 800;
   end

   // Cycles spent inside the current frame
   always_ff @(posedge clock) begin
      act_cnt_reg <= (rst || !frame_active) ? 16'h0000 : act_cnt_reg + 16'h0001;
   end

   // Cycles since the last bit start
   always_ff @(posedge clock) begin
      gap_cnt_reg <= (rst || bit_strobe) ? 16'h0001 : gap_cnt_reg + 16'h0001;
   end

   property p_first_bit;
      frame_start |-> bit_strobe && bit_index == 5'h00;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("frame start without bit zero");

   property p_bit_gap;
      bit_strobe && !frame_start |-> int'(gap_cnt_reg) >= gap_exp - 2
         && int'(gap_cnt_reg) <= gap_exp + 2;
   endproperty
   a_bit_gap: assert property (p_bit_gap) else $error("bit length off");

   property p_frame_len;
      $fell(frame_active) && run_en && !sync_seen && !$past(sync_seen)
         |-> int'(act_cnt_reg) >= len_exp - 3 && int'(act_cnt_reg) <= len_exp + 3;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length off");

   property p_rise_start;
      $rose(frame_active) |-> frame_start;
   endproperty
   a_rise_start: assert property (p_rise_start) else $error("frame rose without start");

   property p_trig;
      $rose(sync_in) && run_en && mode >= PFS_P20_1L && angle_slot == 2'h0
         |-> ##[1:TRIG_CYC] sync_seen;
   endproperty
   a_trig: assert property (p_trig) else $error("sync not detected in time");

   property p_abort_quiet;
      sync_seen |-> ##1 !frame_active [*8];
   endproperty
   a_abort_quiet: assert property (p_abort_quiet) else $error("frame kept after sync");

   property p_abort_cause;
      tx_abort |-> sync_seen;
   endproperty
   a_abort_cause: assert property (p_abort_cause) else $error("abort without sync");

   property p_vel_slot;
      frame_start && frame_is_vel |-> vel_en && frame_slot == angle_slot + 2'h1;
   endproperty
   a_vel_slot: assert property (p_vel_slot) else $error("velocity slot wrong");

   property p_no_vel_1l;
      mode == PFS_P20_1L |-> !frame_is_vel;
   endproperty
   a_no_vel_1l: assert property (p_no_vel_1l) else $error("velocity in one-slot mode");

   // Main scenarios reached
   c_vel: cover property (frame_start && frame_is_vel);
   c_abort: cover property (tx_abort);
   c_async: cover property (frame_start && mode == PFS_A10_250);
endmodule // pfs_fst_props

bind pfs_frame_slot_timer pfs_fst_props u_props (
   .clock(clock), .rst(rst), .sync_in(sync_in), .run_en(run_en), .mode(mode),
   .angle_slot(angle_slot), .vel_en(vel_en), .frame_start(frame_start),
   .bit_strobe(bit_strobe), .frame_active(frame_active), .frame_is_vel(frame_is_vel),
   .frame_slot(frame_slot), .bit_index(bit_index), .tx_abort(tx_abort),
   .sync_seen(sync_seen)
);

// [sim/pfs_ecu_model.sv]
// Purpose: Receiver side that sends sync pulses on request.
// Assumes: Pulse width is given in system cycles, at least three.
// Notes:   Line rests low between pulses.
`timescale 1ns/1ns
module pfs_ecu_model (
   // Clock
   input  wire logic       clock,
   // Request from the bench
   input  wire logic       go,
   input  wire logic [7:0] width,
   // Sync line
   output logic            sync_out
);
   int left = 0;

   // Count the pulse down; updates land just after the edge
   always @(posedge clock) begin
      if (go) begin
         left = int'(width);
      end else if (left > 0) begin
         left = left - 1;
      end
      sync_out <= (left > 0);
   end
endmodule // pfs_ecu_model

// [sim/pfs_frame_slot_timer_tb.sv]
// Purpose: Self-checking bench for the frame and slot timer.
// Assumes: Ticks of 50 and 37.5 system cycles with one cycle of jitter.
// Notes:   Slot starts are judged in a window one tick wide, as tick phase is free.
`timescale 1ns/1ns
module pfs_frame_slot_timer_tb
   import pfs_pkg::*;
;
   logic clock, rst, sync_in, run_en, vel_en, ecu_go, fa_q;
   logic frame_start, bit_strobe, frame_active, frame_is_vel, tx_abort, sync_seen;
   logic [1:0] angle_slot, frame_slot;
   logic [7:0] ecu_width;
   logic [BIT_W-1:0] bit_index;
   pfs_mode_t mode;
   int failures = 0, n_compared = 0, cyc = 0, t_sync = 0, n_seen = 0, n_abort = 0;
   int n_bits = 0;
   integer seed = 32'hC6BDBCCD;
   int q_t[$], q_bits[$];
   logic [1:0] q_slot[$];
   logic q_vel[$];

   pfs_frame_slot_timer dut (
      .clock(clock), .rst(rst), .sync_in(sync_in), .run_en(run_en), .mode(mode),
      .angle_slot(angle_slot), .vel_en(vel_en), .frame_start(frame_start),
      .bit_strobe(bit_strobe), .frame_active(frame_active), .frame_is_vel(frame_is_vel),
      .frame_slot(frame_slot), .bit_index(bit_index), .tx_abort(tx_abort),
      .sync_seen(sync_seen)
   );
   pfs_ecu_model ecu (.clock(clock), .go(ecu_go), .width(ecu_width), .sync_out(sync_in));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Record events; reads see values from before the edge
   always @(posedge clock) begin
      if (sync_seen === 1'b1) begin
         t_sync = cyc - 1;
         n_seen++;
      end
      if (tx_abort === 1'b1) n_abort++;
      if (frame_start === 1'b1) begin
         q_t.push_back(cyc);
         q_slot.push_back(frame_slot);
         q_vel.push_back(frame_is_vel);
         n_bits = 1;
      end else if (bit_strobe === 1'b1) begin
         check("bit index", bit_index, n_bits);
         n_bits++;
      end
      if (frame_active === 1'b0 && fa_q === 1'b1) q_bits.push_back(n_bits);
      fa_q = frame_active;
      cyc++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic results();
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Wait, bounded, for n starts (which 0) or n finished frames (which 1)
   task automatic wait_for(input int which, input int n, input int lim);
      int k = 0;
      while (((which == 0) ? q_t.size() : q_bits.size()) < n && k < lim) begin
         @(negedge clock);
         k++;
      end
      check("event count", (which == 0) ? q_t.size() : q_bits.size(), n);
   endtask

   // Start time from detection, in ticks of p2/2 cycles
   task automatic chk_start(input int n, input int p2, input logic [1:0] s, input logic v);
      int d;
      if (q_t.size() > 0) begin
         d = q_t.pop_front() - t_sync;
         check("slot start", (d >= (n - 1) * p2 / 2 && d <= n * p2 / 2 + 3) ? n : d, n);
         check("frame slot", q_slot.pop_front(), s);
         check("velocity flag", q_vel.pop_front(), v);
      end
   endtask

   task automatic sync_pulse();
      @(negedge clock);
      ecu_width = 8'(3 + {$random(seed)} % 16);
      ecu_go = 1'b1;
      @(negedge clock);
      ecu_go = 1'b0;
   endtask

   // Stop, reconfigure, restart; old events are dropped once settled
   task automatic setup(input pfs_mode_t m, input logic [1:0] a, input logic v);
      @(negedge clock);
      run_en = 1'b0;
      repeat (3) @(negedge clock);
      q_t.delete();
      q_slot.delete();
      q_vel.delete();
      q_bits.delete();
      mode = m;
      angle_slot = a;
      vel_en = v;
      run_en = 1'b1;
   endtask

   initial begin
      #1200000;
      failures++;
      results();
   end

   initial begin
      int k;
      rst = 1'b1;
      run_en = 1'b0;
      mode = PFS_A10_250;
      angle_slot = 2'h0;
      vel_en = 1'b0;
      ecu_go = 1'b0;
      ecu_width = 8'h03;
      fa_q = 1'b0;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      // Sync accepted only in the slot modes
      for (int m = 0; m < 8; m++) begin
         setup(pfs_mode_t'(m), 2'h0, 1'b0);
         k = n_seen;
         sync_pulse();
         repeat (30) @(negedge clock);
         check("sync seen", n_seen - k, (m >= 2) ? 1 : 0);
      end
      setup(PFS_P20_3H, 2'h3, 1'b0);
      k = n_seen;
      sync_pulse();
      repeat (30) @(negedge clock);
      check("sync outside slots", n_seen - k, 1);
      repeat (4500) @(negedge clock);
      check("no frame outside slots", q_t.size(), 0);
      // Free-running short cycle
      setup(PFS_A10_250, 2'h0, 1'b0);
      wait_for(0, 2, 30000);
      if (q_t.size() >= 2) begin
         k = q_t[1] - q_t[0];
         check("async cycle", (k >= 24997 && k <= 25003) ? 500 : k, 500);
         check("async bits", q_bits[0], 13);
      end
      // Angle then velocity in consecutive slots, 16-bit frames
      setup(PFS_P16_3H, 2'h0, 1'b1);
      sync_pulse();
      wait_for(0, 2, 20000);
      chk_start(112, 75, 2'h0, 1'b0);
      chk_start(482, 75, 2'h1, 1'b1);
      wait_for(1, 2, 12000);
      if (q_bits.size() >= 2) check("crc bits", q_bits[0] + q_bits[1], 42);
      // Sync in mid-frame aborts and restarts the slot sequence
      setup(PFS_P20_2H, 2'h0, 1'b0);
      sync_pulse();
      wait_for(0, 1, 6000);
      chk_start(119, 75, 2'h0, 1'b0);
      repeat (500 + {$random(seed)} % 1000) @(negedge clock);
      k = n_abort;
      sync_pulse();
      repeat (10) @(negedge clock);
      check("abort", n_abort - k, 1);
      check("active after abort", frame_active, 1'b0);
      wait_for(0, 1, 6000);
      chk_start(119, 75, 2'h0, 1'b0);
      wait_for(1, 2, 15000);
      if (q_bits.size() >= 2) check("high rate bits", q_bits[1], 25);
      results();
   end
endmodule // pfs_frame_slot_timer_tb
